// file: core/drt_params.svh
// Register offsets, field positions and reset values of the reload timer
`ifndef DRT_PARAMS_SVH
`define DRT_PARAMS_SVH
`define DRT_ADDR_W        9
`define DRT_OFF_PRESC     9'h111
`define DRT_OFF_LOW_CNT   9'h112
`define DRT_OFF_LOW_REL   9'h113
`define DRT_OFF_HIGH_CNT  9'h114
`define DRT_OFF_HIGH_REL  9'h115
`define DRT_OFF_TCTL      9'h14e
`define DRT_OFF_EDGE_CTL  9'h15e
`define DRT_OFF_INSEL     9'h15f
`define DRT_RST_BYTE      8'h00
`define DRT_RST_INSEL     6'h00
`define DRT_CNT_MAX       8'hff
`define DRT_TC_RUN_H      7
`define DRT_TC_RUN_L      6
`define DRT_TC_CASCADE    5
`define DRT_TC_LOW_EXT    4
`define DRT_TC_OVF_H      3
`define DRT_TC_IE_H       2
`define DRT_TC_OVF_L      1
`define DRT_TC_IE_L       0
`define DRT_EC_B_RISE     7
`define DRT_EC_B_FALL     6
`define DRT_EC_B_PEND     5
`define DRT_EC_B_IE       4
`define DRT_EC_A_RISE     3
`define DRT_EC_A_FALL     2
`define DRT_EC_A_PEND     1
`define DRT_EC_A_IE       0
`define DRT_IS_PIN_SEL    0
`define DRT_FILT_CYC      1
`endif

// file: core/drt_pkg.sv
// Types shared by the reload timer modules
package drt_pkg;
	typedef logic [7:0] drt_byte_t;
	typedef struct packed {
		drt_byte_t cnt;
		logic      tick;
	} drt_presc_st_t;
	typedef struct packed {
		logic      sync1;
		logic      sync2;
		logic      level;
		drt_byte_t cnt;
		logic      rise;
		logic      fall;
	} drt_edge_st_t;
	typedef struct packed {
		drt_byte_t presc_rel;
		drt_byte_t low_cnt;
		drt_byte_t low_rel;
		drt_byte_t high_cnt;
		drt_byte_t high_rel;
		drt_byte_t tctl;
		logic [5:0] insel;
		drt_byte_t ectl;
		drt_byte_t rdata;
		logic [3:0] irq;
	} drt_core_st_t;
endpackage

// file: core/drt_if.sv
// Carrier between the timer core and its prescaler
`timescale 1ns/1ps
interface drt_if;
	logic [7:0] reload;
	logic       tick;
	modport core  (output reload, input tick);
	modport presc (input reload, output tick);
endinterface

// file: core/drt_prescale.sv
// Eight-bit programmable prescaler on the cycle clock
`timescale 1ns/1ps
`include "drt_params.svh"
module drt_prescale (
	input  wire logic clk,
	input  wire logic sys_rst,
	drt_if.presc      pif
);
	import drt_pkg::*;
	drt_presc_st_t st_r;
	drt_presc_st_t st_nxt;

	// Count up from the reload value; one tick per 256 - reload cycles
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == `DRT_CNT_MAX) begin
			st_nxt.cnt = pif.reload;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pif.tick = st_r.tick;

	a_presc_reload: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.cnt == `DRT_CNT_MAX) |=> (pif.tick && st_r.cnt == $past(pif.reload)))
		else $error("prescaler did not reload and tick");
endmodule // drt_prescale

// file: core/drt_edge.sv
// Pin synchroniser, optional noise filter and edge detector
`timescale 1ns/1ps
`include "drt_params.svh"
module drt_edge #(
	parameter bit         FILTER   = 1'b0,
	parameter logic [7:0] FILT_CYC = 8'd`DRT_FILT_CYC
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	import drt_pkg::*;
	drt_edge_st_t st_r;
	drt_edge_st_t st_nxt;

	initial begin
		if (FILT_CYC == 8'd0) begin
			$error("FILT_CYC must be at least one");
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.sync1 = pin;
		st_nxt.sync2 = st_r.sync1;
		if (!FILTER) begin
			st_nxt.level = st_r.sync2;
		end else if (st_r.sync2 == st_r.level) begin
			st_nxt.cnt = 8'h00;
		end else if (st_r.cnt + 8'h01 >= FILT_CYC) begin
			// A level shorter than the constant is dropped as noise
			st_nxt.level = st_r.sync2;
			st_nxt.cnt = 8'h00;
		end else begin
			st_nxt.cnt = st_r.cnt + 8'h01;
		end
		st_nxt.rise = st_nxt.level & ~st_r.level;
		st_nxt.fall = ~st_nxt.level & st_r.level;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rise = st_r.rise;
	assign fall = st_r.fall;
endmodule // drt_edge

// file: core/drt_top.sv
// Dual eight-bit reload timer/counter with two edge-detect inputs
`timescale 1ns/1ps
`include "drt_params.svh"
module drt_top #(
	parameter logic [7:0] FILT_CYC = 8'd`DRT_FILT_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic [`DRT_ADDR_W-1:0]   addr,
	input  wire drt_pkg::drt_byte_t       wdata,
	input  wire logic                     wr_stb,
	input  wire logic                     rd_stb,
	output drt_pkg::drt_byte_t            rdata,
	input  wire logic                     pin_a,
	input  wire logic                     pin_b,
	output logic                          irq_low,
	output logic                          irq_high,
	output logic                          irq_edge_a,
	output logic                          irq_edge_b
);
	import drt_pkg::*;

	drt_if        pif ();
	drt_core_st_t st_r;
	drt_core_st_t st_nxt;
	logic [1:0]   pin_rise;
	logic [1:0]   pin_fall;
	logic [1:0]   pins;

	assign pins = {pin_b, pin_a};

	drt_prescale u_presc (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pif     (pif)
	);

	// Index 0 is pin_a, index 1 is pin_b; only pin_b carries the filter
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			drt_edge #(
				.FILTER   (gi == 1),
				.FILT_CYC (FILT_CYC)
			) u_edge (
				.clk     (clk),
				.sys_rst (sys_rst),
				.pin     (pins[gi]),
				.rise    (pin_rise[gi]),
				.fall    (pin_fall[gi])
			);
		end
	endgenerate

	assign pif.reload = st_r.presc_rel;

	logic edge_a_ev;
	logic edge_b_ev;
	logic count_ev;
	logic run_low;
	logic run_high;
	logic cascade;
	logic low_ext;
	logic low_clk;
	logic low_inc;
	logic low_ovf;
	logic high_clk;
	logic high_inc;
	logic high_ovf;
	logic wr_tctl;
	logic wr_ectl;

	always_comb begin
		edge_b_ev = (pin_rise[1] & st_r.ectl[`DRT_EC_B_RISE])
			| (pin_fall[1] & st_r.ectl[`DRT_EC_B_FALL]);
		edge_a_ev = (pin_rise[0] & st_r.ectl[`DRT_EC_A_RISE])
			| (pin_fall[0] & st_r.ectl[`DRT_EC_A_FALL]);
		count_ev = st_r.insel[`DRT_IS_PIN_SEL] ? edge_b_ev : edge_a_ev;
		run_low = st_r.tctl[`DRT_TC_RUN_L];
		run_high = st_r.tctl[`DRT_TC_RUN_H];
		cascade = st_r.tctl[`DRT_TC_CASCADE];
		low_ext = st_r.tctl[`DRT_TC_LOW_EXT];
		low_clk = low_ext ? count_ev : pif.tick;
		low_inc = run_low & low_clk;
		low_ovf = low_inc & (st_r.low_cnt == `DRT_CNT_MAX);
		// Cascading feeds the high counter from the low overflow
		high_clk = cascade ? low_ovf : pif.tick;
		high_inc = run_high & high_clk;
		high_ovf = high_inc & (st_r.high_cnt == `DRT_CNT_MAX);
		wr_tctl = wr_stb && (addr == `DRT_OFF_TCTL);
		wr_ectl = wr_stb && (addr == `DRT_OFF_EDGE_CTL);
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = `DRT_RST_BYTE;
		if (wr_stb) begin
			if (addr == `DRT_OFF_PRESC) begin
				st_nxt.presc_rel = wdata;
			end else if (addr == `DRT_OFF_LOW_REL) begin
				st_nxt.low_rel = wdata;
			end else if (addr == `DRT_OFF_HIGH_REL) begin
				st_nxt.high_rel = wdata;
			end else if (addr == `DRT_OFF_TCTL) begin
				st_nxt.tctl = wdata;
			end else if (addr == `DRT_OFF_EDGE_CTL) begin
				st_nxt.ectl = wdata;
			end else if (addr == `DRT_OFF_INSEL) begin
				st_nxt.insel = wdata[5:0];
			end
		end

		// Low counter; a stopped counter keeps showing its reload value
		if (!run_low) begin
			st_nxt.low_cnt = st_r.low_rel;
		end else if (cascade && high_ovf) begin
			st_nxt.low_cnt = st_r.low_rel;
		end else if (!cascade && low_ovf) begin
			st_nxt.low_cnt = st_r.low_rel;
		end else if (low_inc) begin
			// In 16-bit operation a low overflow alone wraps to zero
			st_nxt.low_cnt = st_r.low_cnt + 8'h01;
		end

		if (!run_high || high_ovf) begin
			st_nxt.high_cnt = st_r.high_rel;
		end else if (high_inc) begin
			st_nxt.high_cnt = st_r.high_cnt + 8'h01;
		end

		// Hardware sets win over a same-cycle software clear
		if (high_ovf) begin
			st_nxt.tctl[`DRT_TC_OVF_H] = 1'b1;
		end
		if (cascade ? high_ovf : low_ovf) begin
			st_nxt.tctl[`DRT_TC_OVF_L] = 1'b1;
		end
		if (edge_b_ev) begin
			st_nxt.ectl[`DRT_EC_B_PEND] = 1'b1;
		end
		if (edge_a_ev) begin
			st_nxt.ectl[`DRT_EC_A_PEND] = 1'b1;
		end

		// Order: low vector, high vector, edge a, edge b
		st_nxt.irq[0] = st_nxt.tctl[`DRT_TC_OVF_L] & st_nxt.tctl[`DRT_TC_IE_L];
		st_nxt.irq[1] = st_nxt.tctl[`DRT_TC_OVF_H] & st_nxt.tctl[`DRT_TC_IE_H];
		st_nxt.irq[2] = st_nxt.ectl[`DRT_EC_A_PEND] & st_nxt.ectl[`DRT_EC_A_IE];
		st_nxt.irq[3] = st_nxt.ectl[`DRT_EC_B_PEND] & st_nxt.ectl[`DRT_EC_B_IE];

		// Reads show state at the edge of the strobe; unmapped reads zero
		if (rd_stb) begin
			if (addr == `DRT_OFF_PRESC) begin
				st_nxt.rdata = st_r.presc_rel;
			end else if (addr == `DRT_OFF_LOW_CNT) begin
				st_nxt.rdata = st_r.low_cnt;
			end else if (addr == `DRT_OFF_LOW_REL) begin
				st_nxt.rdata = st_r.low_rel;
			end else if (addr == `DRT_OFF_HIGH_CNT) begin
				st_nxt.rdata = st_r.high_cnt;
			end else if (addr == `DRT_OFF_HIGH_REL) begin
				st_nxt.rdata = st_r.high_rel;
			end else if (addr == `DRT_OFF_TCTL) begin
				st_nxt.rdata = st_r.tctl;
			end else if (addr == `DRT_OFF_EDGE_CTL) begin
				st_nxt.rdata = st_r.ectl;
			end else if (addr == `DRT_OFF_INSEL) begin
				st_nxt.rdata = {2'b00, st_r.insel};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;
	assign irq_low = st_r.irq[0];
	assign irq_high = st_r.irq[1];
	assign irq_edge_a = st_r.irq[2];
	assign irq_edge_b = st_r.irq[3];

	a_low_ovf_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(!cascade && low_ovf) |=> st_r.tctl[`DRT_TC_OVF_L])
		else $error("low overflow flag not set");

	a_high_ovf_flag: assert property (@(posedge clk) disable iff (sys_rst)
		high_ovf |=> (st_r.tctl[`DRT_TC_OVF_H] && st_r.high_cnt == $past(st_r.high_rel)))
		else $error("high overflow did not flag and reload");

	a_low_reload: assert property (@(posedge clk) disable iff (sys_rst)
		(run_low && !cascade && low_ovf) |=> (st_r.low_cnt == $past(st_r.low_rel)))
		else $error("low counter did not reload on overflow");

	a_stop_reload: assert property (@(posedge clk) disable iff (sys_rst)
		(!run_high && !run_low) |=> (st_r.high_cnt == $past(st_r.high_rel)
			&& st_r.low_cnt == $past(st_r.low_rel)))
		else $error("stopped counter does not hold reload value");

	a_low_count_up: assert property (@(posedge clk) disable iff (sys_rst)
		(run_low && low_clk && st_r.low_cnt != `DRT_CNT_MAX)
			|=> (st_r.low_cnt == $past(st_r.low_cnt) + 8'h01))
		else $error("low counter missed a count");

	a_edge_b_pend: assert property (@(posedge clk) disable iff (sys_rst)
		edge_b_ev |=> st_r.ectl[`DRT_EC_B_PEND])
		else $error("pin_b edge lost");

	a_edge_a_pend: assert property (@(posedge clk) disable iff (sys_rst)
		edge_a_ev |=> st_r.ectl[`DRT_EC_A_PEND])
		else $error("pin_a edge lost");

	a_edge_b_irq: assert property (@(posedge clk) disable iff (sys_rst)
		irq_edge_b == (st_r.ectl[`DRT_EC_B_PEND] && st_r.ectl[`DRT_EC_B_IE]))
		else $error("pin_b request disagrees with pending and enable");

	a_edge_a_irq: assert property (@(posedge clk) disable iff (sys_rst)
		irq_edge_a == (st_r.ectl[`DRT_EC_A_PEND] && st_r.ectl[`DRT_EC_A_IE]))
		else $error("pin_a request disagrees with pending and enable");

	a_timer_irq: assert property (@(posedge clk) disable iff (sys_rst)
		(irq_high == (st_r.tctl[`DRT_TC_OVF_H] && st_r.tctl[`DRT_TC_IE_H]))
			&& (irq_low == (st_r.tctl[`DRT_TC_OVF_L] && st_r.tctl[`DRT_TC_IE_L])))
		else $error("timer request disagrees with flag and enable");

	a_cascade_noflag: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && low_ovf && !high_ovf && !wr_tctl && !st_r.tctl[`DRT_TC_OVF_L])
			|=> !st_r.tctl[`DRT_TC_OVF_L])
		else $error("low flag set by low overflow in 16-bit mode");

	a_cascade_reload: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && run_low && high_ovf) |=> (st_r.low_cnt == $past(st_r.low_rel)
			&& st_r.tctl[`DRT_TC_OVF_L] && st_r.tctl[`DRT_TC_OVF_H]))
		else $error("16-bit overflow did not reload both halves");

	// Source selection, holding and sticky flags; these guard decode mistakes that counts alone would hide
	a_pin_a_select: assert property (@(posedge clk) disable iff (sys_rst)
		(!st_r.insel[`DRT_IS_PIN_SEL] && !pin_rise[0] && !pin_fall[0]) |-> !count_ev)
		else $error("unselected pin_b edge was counted");

	a_pin_b_select: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.insel[`DRT_IS_PIN_SEL] && !pin_rise[1] && !pin_fall[1]) |-> !count_ev)
		else $error("unselected pin_a edge was counted");

	a_no_count_cond: assert property (@(posedge clk) disable iff (sys_rst)
		(!st_r.ectl[`DRT_EC_B_RISE] && !st_r.ectl[`DRT_EC_B_FALL]
			&& !st_r.ectl[`DRT_EC_A_RISE] && !st_r.ectl[`DRT_EC_A_FALL]) |-> !count_ev)
		else $error("count event with no edge selected");

	a_b_no_detect: assert property (@(posedge clk) disable iff (sys_rst)
		(!st_r.ectl[`DRT_EC_B_RISE] && !st_r.ectl[`DRT_EC_B_FALL]) |-> !edge_b_ev)
		else $error("pin_b edge seen with detection off");

	a_b_both_edges: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.ectl[`DRT_EC_B_RISE] && st_r.ectl[`DRT_EC_B_FALL] && (pin_rise[1] || pin_fall[1])) |-> edge_b_ev)
		else $error("pin_b dual edge missed");

	a_a_both_edges: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.ectl[`DRT_EC_A_RISE] && st_r.ectl[`DRT_EC_A_FALL] && (pin_rise[0] || pin_fall[0])) |-> edge_a_ev)
		else $error("pin_a dual edge missed");

	a_a_no_detect: assert property (@(posedge clk) disable iff (sys_rst)
		(!st_r.ectl[`DRT_EC_A_RISE] && !st_r.ectl[`DRT_EC_A_FALL]) |-> !edge_a_ev)
		else $error("pin_a edge seen with detection off");

	a_low_stop: assert property (@(posedge clk) disable iff (sys_rst)
		!run_low |=> (st_r.low_cnt == $past(st_r.low_rel)))
		else $error("stopped low counter does not follow its reload");

	a_high_stop: assert property (@(posedge clk) disable iff (sys_rst)
		!run_high |=> (st_r.high_cnt == $past(st_r.high_rel)))
		else $error("stopped high counter does not follow its reload");

	a_low_idle: assert property (@(posedge clk) disable iff (sys_rst)
		(run_low && !low_clk) |=> (st_r.low_cnt == $past(st_r.low_cnt)))
		else $error("low counter moved without a clock");

	a_mode0_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(!cascade && !low_ext) |-> (low_clk == pif.tick && high_clk == pif.tick))
		else $error("mode 0 counters not on prescaler");

	a_mode1_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(!cascade && low_ext) |-> (low_clk == count_ev && high_clk == pif.tick))
		else $error("mode 1 clock sources wrong");

	a_mode2_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && !low_ext) |-> (low_clk == pif.tick && high_clk == low_ovf))
		else $error("mode 2 clock sources wrong");

	a_mode3_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && low_ext) |-> (low_clk == count_ev && high_clk == low_ovf))
		else $error("mode 3 clock sources wrong");

	a_cascade_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && low_ovf && !high_ovf) |=> (st_r.low_cnt == 8'h00))
		else $error("16-bit low half did not wrap to zero");

	a_high_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.tctl[`DRT_TC_OVF_H] && !wr_tctl) |=> st_r.tctl[`DRT_TC_OVF_H])
		else $error("high overflow flag cleared without a write");

	a_low_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.tctl[`DRT_TC_OVF_L] && !wr_tctl) |=> st_r.tctl[`DRT_TC_OVF_L])
		else $error("low overflow flag cleared without a write");

	a_b_pend_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.ectl[`DRT_EC_B_PEND] && !wr_ectl) |=> st_r.ectl[`DRT_EC_B_PEND])
		else $error("pin_b pending cleared without a write");

	a_a_pend_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.ectl[`DRT_EC_A_PEND] && !wr_ectl) |=> st_r.ectl[`DRT_EC_A_PEND])
		else $error("pin_a pending cleared without a write");

	a_high_vector: assert property (@(posedge clk) disable iff (sys_rst)
		!st_r.tctl[`DRT_TC_IE_H] |-> !irq_high)
		else $error("high request raised while disabled");
endmodule // drt_top

// file: testbench/drt_pulse_src.sv
// Pulse source model driving the two external count pins
`timescale 1ns/1ps
module drt_pulse_src (
	input  wire logic clk,
	output logic      pin_a,
	output logic      pin_b
);
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// Each level is held four cycles so it clears the sync and filter stages
	task automatic pulse(input logic sel, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			if (sel) pin_b <= 1'b1;
			else pin_a <= 1'b1;
			repeat (4) @(posedge clk);
			if (sel) pin_b <= 1'b0;
			else pin_a <= 1'b0;
		end
		repeat (8) @(posedge clk);
		#1;
	endtask
endmodule // drt_pulse_src

// file: testbench/drt_top_tb.sv
// Self-checking bench for the dual reload timer/counter
`timescale 1ns/1ps
`include "drt_params.svh"
module drt_top_tb;
	import drt_pkg::*;
	logic                   clk;
	logic                   sys_rst;
	logic [`DRT_ADDR_W-1:0] addr;
	drt_byte_t              wdata;
	logic                   wr_stb;
	logic                   rd_stb;
	drt_byte_t              rdata;
	logic                   pin_a;
	logic                   pin_b;
	logic                   irq_low;
	logic                   irq_high;
	logic                   irq_edge_a;
	logic                   irq_edge_b;
	int                     fails;
	int                     tests_run;
	drt_byte_t              rd;

	drt_top #(.FILT_CYC(8'd1)) u_drt_top (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_a(pin_a), .pin_b(pin_b),
		.irq_low(irq_low), .irq_high(irq_high), .irq_edge_a(irq_edge_a), .irq_edge_b(irq_edge_b));
	drt_pulse_src u_drt_pulse_src (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [8:0] a, input drt_byte_t d);
		@(posedge clk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rdb(input logic [8:0] a);
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		rd = rdata;
	endtask
	task automatic chk(input drt_byte_t exp, input drt_byte_t got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic chk_bit(input logic exp, input logic got);
		chk({7'h00, exp}, {7'h00, got});
	endtask

	task automatic t_reset;
		logic [8:0] regs [9];
		regs = '{9'h111, 9'h112, 9'h113, 9'h114, 9'h115, 9'h14e, 9'h15e, 9'h15f, 9'h100};
		foreach (regs[i]) begin
			rdb(regs[i]);
			chk(`DRT_RST_BYTE, rd);
		end
		wr(`DRT_OFF_INSEL, 8'hff);
		rdb(`DRT_OFF_INSEL);
		chk(8'h3f, rd);
		wr(`DRT_OFF_INSEL, 8'h00);
		// New prescaler value only lands after the 256-cycle period from reset
		wr(`DRT_OFF_PRESC, 8'hfe);
		cyc(300);
		$display("test reset done");
	endtask

	task automatic t_mode0;
		wr(`DRT_OFF_LOW_REL, 8'hf0);
		wr(`DRT_OFF_HIGH_REL, 8'he0);
		wr(`DRT_OFF_TCTL, 8'hc5);
		cyc(26);
		chk_bit(1'b0, irq_low);
		cyc(10);
		chk_bit(1'b1, irq_low);
		chk_bit(1'b0, irq_high);
		cyc(22);
		chk_bit(1'b0, irq_high);
		cyc(10);
		chk_bit(1'b1, irq_high);
		rdb(`DRT_OFF_TCTL);
		chk(8'hcf, rd);
		wr(`DRT_OFF_TCTL, 8'hc0);
		cyc(70);
		chk_bit(1'b0, irq_low);
		chk_bit(1'b0, irq_high);
		rdb(`DRT_OFF_TCTL);
		chk(8'hca, rd);
		$display("test mode0 done");
	endtask

	task automatic t_stop;
		wr(`DRT_OFF_TCTL, 8'h00);
		wr(`DRT_OFF_LOW_REL, 8'h5a);
		wr(`DRT_OFF_HIGH_REL, 8'ha5);
		wr(`DRT_OFF_LOW_CNT, 8'h33);
		rdb(`DRT_OFF_LOW_CNT);
		chk(8'h5a, rd);
		rdb(`DRT_OFF_HIGH_CNT);
		chk(8'ha5, rd);
		$display("test stop done");
	endtask

	task automatic t_cascade;
		wr(`DRT_OFF_LOW_REL, 8'hfe);
		wr(`DRT_OFF_HIGH_REL, 8'hfe);
		wr(`DRT_OFF_TCTL, 8'he4);
		cyc(12);
		rdb(`DRT_OFF_TCTL);
		chk(8'he4, rd);
		cyc(490);
		chk_bit(1'b0, irq_high);
		cyc(30);
		chk_bit(1'b1, irq_high);
		rdb(`DRT_OFF_TCTL);
		chk(8'hee, rd);
		$display("test cascade done");
	endtask

	task automatic t_edges;
		drt_byte_t n;
		wr(`DRT_OFF_LOW_REL, 8'h00);
		for (int s = 0; s < 2; s++) begin
			for (int e = 0; e < 4; e++) begin
				n = (e == 3) ? 8'h04 : ((e == 0) ? 8'h00 : 8'h02);
				wr(`DRT_OFF_TCTL, 8'h00);
				wr(`DRT_OFF_INSEL, {7'h00, s[0]});
				wr(`DRT_OFF_EDGE_CTL, {e[1:0], 2'b00, e[1:0], 2'b00});
				wr(`DRT_OFF_TCTL, 8'h50);
				u_drt_pulse_src.pulse(s[0], 2);
				u_drt_pulse_src.pulse(!s[0], 1);
				rdb(`DRT_OFF_LOW_CNT);
				chk(n, rd);
				rdb(`DRT_OFF_EDGE_CTL);
				chk({e[1:0], |e, 1'b0, e[1:0], |e, 1'b0}, rd);
			end
		end
		$display("test edges done");
	endtask

	task automatic t_ext_ovf;
		wr(`DRT_OFF_TCTL, 8'h00);
		wr(`DRT_OFF_EDGE_CTL, 8'h08);
		wr(`DRT_OFF_INSEL, 8'h00);
		wr(`DRT_OFF_LOW_REL, 8'hfd);
		wr(`DRT_OFF_HIGH_REL, 8'hff);
		wr(`DRT_OFF_TCTL, 8'hf4);
		u_drt_pulse_src.pulse(1'b0, 2);
		chk_bit(1'b0, irq_high);
		u_drt_pulse_src.pulse(1'b0, 1);
		chk_bit(1'b1, irq_high);
		wr(`DRT_OFF_TCTL, 8'h00);
		wr(`DRT_OFF_LOW_REL, 8'hfe);
		wr(`DRT_OFF_TCTL, 8'h51);
		u_drt_pulse_src.pulse(1'b0, 1);
		chk_bit(1'b0, irq_low);
		u_drt_pulse_src.pulse(1'b0, 1);
		chk_bit(1'b1, irq_low);
		$display("test ext_ovf done");
	endtask

	task automatic t_edge_irq;
		wr(`DRT_OFF_TCTL, 8'h00);
		wr(`DRT_OFF_EDGE_CTL, 8'h99);
		u_drt_pulse_src.pulse(1'b0, 1);
		chk_bit(1'b1, irq_edge_a);
		chk_bit(1'b0, irq_edge_b);
		u_drt_pulse_src.pulse(1'b1, 1);
		chk_bit(1'b1, irq_edge_b);
		wr(`DRT_OFF_EDGE_CTL, 8'h88);
		u_drt_pulse_src.pulse(1'b0, 1);
		u_drt_pulse_src.pulse(1'b1, 1);
		chk_bit(1'b0, irq_edge_a);
		chk_bit(1'b0, irq_edge_b);
		rdb(`DRT_OFF_EDGE_CTL);
		chk(8'haa, rd);
		$display("test edge_irq done");
	endtask

	task automatic test_done;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The run needs about 1600 cycles; the limit allows about fifteen times that
	initial begin
		#1000000;
		fails++;
		test_done();
	end

	initial begin
		sys_rst   = 1'b1;
		addr      = '0;
		wdata     = '0;
		wr_stb    = 1'b0;
		rd_stb    = 1'b0;
		fails     = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_mode0();
		t_stop();
		t_cascade();
		t_edges();
		t_ext_ovf();
		t_edge_irq();
		test_done();
	end
endmodule // drt_top_tb
